// ===== icr_defs.vh
// Constants for the interrupt controller register front end.
// Assumes a 13-bit byte address: bit 12 picks the CPU interface map.
`ifndef ICR_DEFS_VH
`define ICR_DEFS_VH
`define ICR_CPU_SEL_BIT 12
`define ICR_D_CTRL 12'h000
`define ICR_D_TYPE 12'h004
`define ICR_D_IMPL 12'h008
`define ICR_D_SECURITY 12'h080
`define ICR_D_ENSET 12'h100
`define ICR_D_ENCLR 12'h180
`define ICR_D_PENDSET 12'h200
`define ICR_D_PENDCLR 12'h280
`define ICR_D_ACTIVE 12'h300
`define ICR_D_PRIO 12'h400
`define ICR_D_TARGET 12'h800
`define ICR_D_CFG 12'hc00
`define ICR_D_SGI 12'hf00
`define ICR_D_IDENT 12'hfd0
`define ICR_RANGE8_MASK 12'hfe0
`define ICR_RANGE2_MASK 12'hff8
`define ICR_C_CTRL 12'h000
`define ICR_C_PMASK 12'h004
`define ICR_C_BINPT 12'h008
`define ICR_C_ACK 12'h00c
`define ICR_C_EOI 12'h010
`define ICR_C_RUNPRI 12'h014
`define ICR_C_HIPEND 12'h018
`define ICR_C_ABINPT 12'h01c
`define ICR_C_IMPL 12'h0fc
`define ICR_SPURIOUS 32'h000003ff
`define ICR_IDLE_PRIO 8'hff
`define ICR_BP_RESET 3'h2
`define ICR_ENABLE_RESET 32'h00000000
`define ICR_CFG_RESET 64'h0000000000000000
`define ICR_TARGET_ALL 8'h03
`endif

// ===== icr_regs.v
// Register front end and prioritisation for a 32-source, two-processor
// interrupt controller. Assumes a single-cycle strobe bus whose master
// supplies the security attribute and processor number with every access.
//
// The implementer's own choice: the address-and-strobe port.
`default_nettype none
`include "icr_defs.vh"
module icr_regs #(
    parameter SEC_EXT = 1,
    parameter UNIPROC = 0,
    // Identification values below are arbitrary.
    parameter [31:0] DIST_IMPL_ID = 32'h00001234,
    parameter [31:0] CPU_IMPL_ID = 32'h00005678,
    parameter [31:0] IDENT_WORD = 32'h0000005a
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [12:0] addr,
    input wire [31:0] wdata,
    input wire [3:0] be,
    input wire wr,
    input wire rd,
    input wire sec,
    input wire cpu_id,
    input wire [15:0] irq_src,
    output reg [31:0] rdata,
    output reg [1:0] irq
);

// Non-secure view of an 8-bit priority: the top half of the range only.
function [7:0] ns_wr;
    input [7:0] v;
    begin
        ns_wr = {1'b1, v[7:1]};
    end
endfunction

function [7:0] ns_rd;
    input [7:0] v;
    begin
        ns_rd = v[7] ? {v[6:0], 1'b0} : 8'h00;
    end
endfunction

reg dist_en_s;
reg dist_en_ns;
reg [1:0] cen_s;
reg [1:0] cen_ns;
reg [2:0] bp_s [0:1];
reg [2:0] bp_ns [0:1];
reg [7:0] pmr [0:1];
reg [7:0] rpr [0:1];
reg [4:0] act_id [0:1];
reg [1:0] busy;
reg [31:0] isns [0:1];
reg [31:0] enable;
reg [31:0] pending;
reg [31:0] active;
reg [7:0] prio [0:31];
reg [63:0] cfg;
reg [15:0] src_q;

wire acc_s = sec | (SEC_EXT == 0);
wire k = (UNIPROC != 0) ? 1'b0 : cpu_id;
wire [11:0] off = {addr[11:2], 2'b00};
wire csel = addr[`ICR_CPU_SEL_BIT];
wire full = (be == 4'hf);
wire wr_d = wr & ~csel;
wire wr_c = wr & csel & full;
wire [31:0] ns_ok = acc_s ? 32'hffffffff : isns[k];

// Block decode shared by the read mux and the write logic, so that the
// priority and configuration windows can never disagree.
function in_block;
    input [11:0] o;
    input [11:0] mask;
    input [11:0] base;
    begin
        in_block = ((o & mask) == base);
    end
endfunction

wire is_prio = in_block(off, `ICR_RANGE8_MASK, `ICR_D_PRIO);
wire is_target = in_block(off, `ICR_RANGE8_MASK, `ICR_D_TARGET);
wire is_cfg = in_block(off, `ICR_RANGE2_MASK, `ICR_D_CFG);
// The identification block sits at the very top of the map.
wire is_ident = (off >= `ICR_D_IDENT);

// Highest pending eligible interrupt, evaluated per processor because
// the security grouping is banked per processor.
reg [1:0] hp_ok;
reg [4:0] hp_id [0:1];
reg [7:0] hp_pr [0:1];
reg [1:0] grp_en;
reg [1:0] next_irq;
integer c;
integer i;
always @* begin
    for (c = 0; c < 2; c = c + 1) begin
        hp_ok[c] = 1'b0;
        hp_id[c] = 5'd0;
        hp_pr[c] = `ICR_IDLE_PRIO;
        for (i = 0; i < 32; i = i + 1) begin
            if (pending[i] & enable[i] & ~active[i]
                & (isns[c][i] ? dist_en_ns : dist_en_s)
                & (~hp_ok[c] | (prio[i] < hp_pr[c]))) begin
                hp_ok[c] = 1'b1;
                hp_id[c] = i[4:0];
                hp_pr[c] = prio[i];
            end
        end
        grp_en[c] = isns[c][hp_id[c]] ? cen_ns[c] : cen_s[c];
        next_irq[c] = hp_ok[c] & grp_en[c] & ~busy[c]
            & (hp_pr[c] < pmr[c]) & (hp_pr[c] < rpr[c]);
    end
end

// What the accessing processor may see of its highest pending interrupt.
wire bank_en = acc_s ? cen_s[k] : cen_ns[k];
wire hp_view = hp_ok[k] & grp_en[k] & bank_en
    & (acc_s | isns[k][hp_id[k]]);
wire ack_go = rd & csel & (off == `ICR_C_ACK) & hp_view & ~busy[k]
    & (hp_pr[k] < pmr[k]);
wire eoi_go = wr_c & (off == `ICR_C_EOI) & busy[k]
    & (wdata[9:0] == {5'd0, act_id[k]}) & (acc_s | isns[k][act_id[k]]);

// Pending and enable updates; hardware and software sets are applied
// after the clears so that a set in the same cycle is never lost.
reg [31:0] next_pending;
reg [31:0] next_enable;
reg [31:0] hw_set;
integer j;
always @* begin
    hw_set = 32'h00000000;
    // Edge mode sets pending once per rising edge; level mode keeps
    // setting it while the source stays high.
    for (j = 0; j < 16; j = j + 1) begin
        if (cfg[2 * (j + 16) + 1]) begin
            hw_set[j + 16] = irq_src[j] & ~src_q[j];
        end else begin
            hw_set[j + 16] = irq_src[j];
        end
    end
    next_pending = pending;
    next_enable = enable;
    if (wr_d & full & (off == `ICR_D_PENDCLR)) begin
        next_pending = next_pending & ~(wdata & ns_ok);
    end
    if (ack_go) begin
        next_pending[hp_id[k]] = 1'b0;
    end
    if (wr_d & full & (off == `ICR_D_PENDSET)) begin
        next_pending = next_pending | (wdata & ns_ok);
    end
    // A Non-secure trigger of a Secure interrupt is dropped silently.
    if (wr_d & full & (off == `ICR_D_SGI)) begin
        if (ns_ok[wdata[3:0]]) begin
            next_pending[wdata[3:0]] = 1'b1;
        end
    end
    next_pending = next_pending | hw_set;
    if (wr_d & full & (off == `ICR_D_ENCLR)) begin
        next_enable = next_enable & ~(wdata & ns_ok);
    end
    if (wr_d & full & (off == `ICR_D_ENSET)) begin
        next_enable = next_enable | (wdata & ns_ok);
    end
end

// Read data, decoded combinationally and registered one cycle later.
reg [31:0] next_rdata;
reg [4:0] pi;
integer b;
always @* begin
    next_rdata = 32'h00000000;
    pi = 5'd0;
    if (~csel) begin
        case (off)
            `ICR_D_CTRL: begin
                next_rdata[0] = acc_s ? dist_en_s : dist_en_ns;
            end
            `ICR_D_TYPE: begin
                next_rdata[10] = (SEC_EXT != 0);
                next_rdata[5] = (UNIPROC == 0);
            end
            `ICR_D_IMPL: begin
                next_rdata = DIST_IMPL_ID;
            end
            `ICR_D_SECURITY: begin
                next_rdata = acc_s ? isns[k] : 32'h0;
            end
            `ICR_D_ENSET: begin
                next_rdata = enable & ns_ok;
            end
            `ICR_D_ENCLR: begin
                next_rdata = enable & ns_ok;
            end
            `ICR_D_PENDSET: begin
                next_rdata = pending & ns_ok;
            end
            `ICR_D_PENDCLR: begin
                next_rdata = pending & ns_ok;
            end
            `ICR_D_ACTIVE: begin
                next_rdata = active & ns_ok;
            end
            default: begin
                if (is_prio) begin
                    for (b = 0; b < 4; b = b + 1) begin
                        pi = {off[4:2], b[1:0]};
                        next_rdata[8 * b +: 8] = acc_s ? prio[pi]
                            : (isns[k][pi] ? ns_rd(prio[pi]) : 8'h00);
                    end
                end else if (is_target && UNIPROC == 0) begin
                    // Both processors are always targeted; not writable.
                    next_rdata = {4{`ICR_TARGET_ALL}};
                end else if (is_cfg) begin
                    next_rdata = off[2] ? cfg[63:32] : cfg[31:0];
                end else if (is_ident) begin
                    next_rdata = IDENT_WORD;
                end
            end
        endcase
    end else begin
        case (off)
            `ICR_C_CTRL: begin
                next_rdata[0] = acc_s ? cen_s[k] : cen_ns[k];
                next_rdata[1] = acc_s & cen_ns[k];
            end
            `ICR_C_PMASK: begin
                next_rdata[7:0] = acc_s ? pmr[k] : ns_rd(pmr[k]);
            end
            `ICR_C_BINPT: begin
                next_rdata[2:0] = acc_s ? bp_s[k] : bp_ns[k];
            end
            `ICR_C_ACK: begin
                // The same condition that makes the ID active returns it.
                next_rdata = ack_go ? {27'd0, hp_id[k]}
                    : `ICR_SPURIOUS;
            end
            `ICR_C_RUNPRI: begin
                next_rdata[7:0] = acc_s ? rpr[k] : ns_rd(rpr[k]);
            end
            `ICR_C_HIPEND: begin
                next_rdata = hp_view ? {27'd0, hp_id[k]}
                    : `ICR_SPURIOUS;
            end
            `ICR_C_ABINPT: begin
                // Without security support the alias does not exist.
                if (acc_s && SEC_EXT != 0) begin
                    next_rdata[2:0] = bp_ns[k];
                end
            end
            `ICR_C_IMPL: begin
                next_rdata = CPU_IMPL_ID;
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end
end

integer n;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        dist_en_s <= 1'b0;
        dist_en_ns <= 1'b0;
        cen_s <= 2'b00;
        cen_ns <= 2'b00;
        busy <= 2'b00;
        enable <= `ICR_ENABLE_RESET;
        pending <= 32'h00000000;
        active <= 32'h00000000;
        cfg <= `ICR_CFG_RESET;
        src_q <= 16'h0000;
        rdata <= 32'h00000000;
        irq <= 2'b00;
        for (n = 0; n < 2; n = n + 1) begin
            bp_s[n] <= `ICR_BP_RESET;
            bp_ns[n] <= `ICR_BP_RESET;
            pmr[n] <= 8'h00;
            rpr[n] <= `ICR_IDLE_PRIO;
            act_id[n] <= 5'd0;
            isns[n] <= 32'h00000000;
        end
        for (n = 0; n < 32; n = n + 1) begin
            prio[n] <= 8'h00;
        end
    end else if (ce) begin
        // With ce low every register holds, read data included, so a
        // stalled master still finds its answer when the clock resumes.
        rdata <= rd ? next_rdata : 32'h00000000;
        irq <= next_irq;
        src_q <= irq_src;
        pending <= next_pending;
        enable <= next_enable;
        if (ack_go) begin
            active[hp_id[k]] <= 1'b1;
            busy[k] <= 1'b1;
            act_id[k] <= hp_id[k];
            rpr[k] <= hp_pr[k];
        end
        // Only one interrupt may be active per processor; nesting would
        // need a priority stack, so a second acknowledge reads spurious.
        if (eoi_go) begin
            active[act_id[k]] <= 1'b0;
            busy[k] <= 1'b0;
            rpr[k] <= `ICR_IDLE_PRIO;
        end
        if (wr_d) begin
            // Halfword writes land only where byte writes are allowed.
            if (is_prio) begin
                for (n = 0; n < 4; n = n + 1) begin
                    if (be[n] & acc_s) begin
                        prio[{off[4:2], n[1:0]}] <= wdata[8 * n +: 8];
                    end else if (be[n] & isns[k][{off[4:2], n[1:0]}]) begin
                        prio[{off[4:2], n[1:0]}] <= ns_wr(wdata[8 * n +: 8]);
                    end
                end
            end
            if (full) begin
                if (off == `ICR_D_CTRL && acc_s) begin
                    dist_en_s <= wdata[0];
                end else if (off == `ICR_D_CTRL) begin
                    dist_en_ns <= wdata[0];
                end
                if (off == `ICR_D_SECURITY && acc_s && SEC_EXT != 0) begin
                    isns[k] <= wdata;
                end
                if (is_cfg) begin
                    if (off[2]) begin
                        cfg[63:32] <= wdata;
                    end else begin
                        cfg[31:0] <= wdata;
                    end
                end
            end
        end
        if (wr_c) begin
            if (off == `ICR_C_CTRL && acc_s) begin
                cen_s[k] <= wdata[0];
                cen_ns[k] <= wdata[1];
            end else if (off == `ICR_C_CTRL) begin
                cen_ns[k] <= wdata[0];
            end
            if (off == `ICR_C_PMASK && acc_s) begin
                pmr[k] <= wdata[7:0];
            end else if (off == `ICR_C_PMASK && pmr[k][7]) begin
                pmr[k] <= ns_wr(wdata[7:0]);
            end
            if (off == `ICR_C_BINPT && acc_s) begin
                bp_s[k] <= wdata[2:0];
            end else if (off == `ICR_C_BINPT) begin
                bp_ns[k] <= wdata[2:0];
            end
            if (off == `ICR_C_ABINPT && acc_s && SEC_EXT != 0) begin
                bp_ns[k] <= wdata[2:0];
            end
        end
    end
end

endmodule
`default_nettype wire

// ===== icr_regs_props.sv
// Assertions on the register port of the interrupt controller.
// Assumes the one-cycle strobe bus and the registered read data.
`default_nettype none
module icr_regs_props #(
    parameter UNIPROC = 0
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [12:0] addr,
    input wire [31:0] wdata,
    input wire [3:0] be,
    input wire wr,
    input wire rd,
    input wire sec,
    input wire cpu_id,
    input wire [15:0] irq_src,
    input wire [31:0] rdata,
    input wire [1:0] irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] den;
    logic [3:0] cen;
    logic rq;
    assign rq = rd && ce;
    // Shadow enables by bank, so irq checks need no design internals.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            den <= 2'h0;
            cen <= 4'h0;
        end else if (wr && ce && be == 4'hf && addr == 13'h0000) begin
            den[sec] <= wdata[0];
        end else if (wr && ce && be == 4'hf && addr == 13'h1000) begin
            cen[{cpu_id, sec}] <= |wdata[1:0];
        end
    end
    reset_clear_a: assert property ($fell(rst) |-> rdata == 32'h0 && irq == 2'h0)
        else $error("outputs not clear after reset");
    rdata_pulse_a: assert property (rdata != 32'h0 |-> $past(rq))
        else $error("read data without a read");
    rsv_raz_a: assert property (rq && (addr == 13'h000c ||
        addr[12:7] == 6'h07) |=> rdata == 32'h0)
        else $error("reserved address not zero");
    wo_reads_a: assert property (rq && (addr[12:2] == 11'h3c0 ||
        addr[12:2] == 11'h404) |=> rdata == 32'h0)
        else $error("write-only register readable");
    sec_only_a: assert property (rq && !sec && (addr[12:2] == 11'h020 ||
        addr[12:2] == 11'h407) |=> rdata == 32'h0)
        else $error("secure-only register seen non-secure");
    target_ro_a: assert property (rq && addr[12:5] == 8'h40 |=>
        rdata == (UNIPROC ? 32'h0 : 32'h03030303))
        else $error("target register value wrong");
    dist_off_a: assert property (den == 2'h0 [*3] |-> irq == 2'h0)
        else $error("irq while distributor off");
    cpu_off_a: assert property (cen[1:0] == 2'h0 [*3] |-> !irq[0])
        else $error("irq while interface off");
    ack_spur_a: assert property (rq && (addr == 13'h100c ||
        addr == 13'h1018) && cen[{cpu_id, 1'b0} +: 2] == 2'h0
        |=> rdata == 32'h000003ff)
        else $error("disabled interface gave an id");
    cover property (rq && addr == 13'h100c ##1 rdata != 32'h3ff);
    cover property ($rose(irq[0]));
    cover property (rq && !sec && addr == 13'h0080);
endmodule
bind icr_regs icr_regs_props #(.UNIPROC(UNIPROC)) props (.clk(clk),
    .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .be(be), .wr(wr),
    .rd(rd), .sec(sec), .cpu_id(cpu_id), .irq_src(irq_src),
    .rdata(rdata), .irq(irq));
`default_nettype wire

// ===== icr_cpu_model.sv
// Processor bus master model for the register front end.
// Assumes read data stand in the cycle after the read strobe.
`default_nettype none
module icr_cpu_model (
    input wire logic clk,
    input wire logic [31:0] rdata,
    output logic [12:0] addr,
    output logic [31:0] wdata,
    output logic [3:0] be,
    output logic wr,
    output logic rd,
    output logic sec,
    output logic cpu_id
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr = 13'h0000;
        wdata = 32'h0;
        be = 4'h0;
        wr = 1'b0;
        rd = 1'b0;
        sec = 1'b0;
        cpu_id = 1'b0;
    end
    // Only word and byte enables are issued, never a halfword.
    task automatic access(input logic w, input logic [12:0] a,
        input logic [31:0] d, input logic [3:0] b, input logic s,
        input logic c, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= b;
        sec <= s;
        cpu_id <= c;
        wr <= w;
        rd <= ~w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        // Released data flips so a stale value is never mistaken for new.
        wdata <= ~d;
        @(negedge clk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

// ===== icr_regs_test.sv
// Self-checking bench for the interrupt controller register front end.
// Assumes icr_regs with default parameters and the bus model beside it.
`default_nettype none
`include "icr_defs.vh"
module icr_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [15:0] irq_src = 16'h0;
    wire [12:0] addr;
    wire [31:0] wdata;
    wire [31:0] rdata;
    wire [3:0] be;
    wire wr, rd, sec, cpu_id;
    wire [1:0] irq;
    int checks = 0;
    int mismatches = 0;
    localparam logic [31:0] BP = {29'h0, `ICR_BP_RESET};
    icr_regs DUT (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .be(be), .wr(wr), .rd(rd), .sec(sec),
        .cpu_id(cpu_id), .irq_src(irq_src), .rdata(rdata), .irq(irq));
    icr_cpu_model cpu (.clk(clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .be(be), .wr(wr), .rd(rd), .sec(sec),
        .cpu_id(cpu_id));
    always #25 clk = ~clk;
    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic put(logic [12:0] a, logic [31:0] d, logic s, logic c);
        logic [31:0] q;
        cpu.access(1'b1, a, d, 4'hf, s, c, q);
    endtask
    task automatic get(string n, logic [12:0] a, logic [31:0] e,
        logic s, logic c);
        logic [31:0] q;
        cpu.access(1'b0, a, 32'h0, 4'hf, s, c, q);
        chk(n, e, q);
    endtask
    task automatic t_reset;
        get("dctl", 13'h0000, 32'h0, 1'b1, 1'b0);
        get("cctl", 13'h1000, 32'h0, 1'b1, 1'b1);
        get("ack", 13'h100c, `ICR_SPURIOUS, 1'b1, 1'b0);
        get("runpri", 13'h1014, 32'hff, 1'b1, 1'b0);
        get("bp", 13'h1008, BP, 1'b1, 1'b0);
        get("active", 13'h0300, 32'h0, 1'b1, 1'b0);
        $display("reset values done");
    endtask
    task automatic t_access;
        logic [31:0] q;
        put(13'h000c, 32'hffffffff, 1'b1, 1'b0);
        get("rsv", 13'h000c, 32'h0, 1'b1, 1'b0);
        put(13'h1020, 32'hffffffff, 1'b1, 1'b0);
        get("crsv", 13'h1020, 32'h0, 1'b1, 1'b0);
        put(13'h0300, 32'hffffffff, 1'b1, 1'b0);
        get("active ro", 13'h0300, 32'h0, 1'b1, 1'b0);
        get("sgi", 13'h0f00, 32'h0, 1'b1, 1'b0);
        put(13'h0804, 32'h0, 1'b1, 1'b0);
        get("targets", 13'h0804, 32'h03030303, 1'b1, 1'b0);
        cpu.access(1'b1, 13'h0408, 32'h00800000, 4'h4, 1'b1, 1'b0, q);
        get("prio byte", 13'h0408, 32'h00800000, 1'b1, 1'b0);
        @(posedge clk);
        irq_src <= 16'h0001;
        get("hw pend", 13'h0200, 32'h00010000, 1'b1, 1'b0);
        irq_src <= 16'h0000;
        put(13'h0280, 32'h00010000, 1'b1, 1'b0);
        get("hw clr", 13'h0200, 32'h0, 1'b1, 1'b0);
        $display("access kinds done");
    endtask
    task automatic t_bank;
        put(13'h1008, 32'h3, 1'b1, 1'b0);
        get("bp ns", 13'h1008, BP, 1'b0, 1'b0);
        get("bp s", 13'h1008, 32'h3, 1'b1, 1'b0);
        get("bp cpu1", 13'h1008, BP, 1'b1, 1'b1);
        put(13'h0080, 32'h1, 1'b1, 1'b1);
        get("isr cpu0", 13'h0080, 32'h0, 1'b1, 1'b0);
        get("isr cpu1", 13'h0080, 32'h1, 1'b1, 1'b1);
        put(13'h0080, 32'h0, 1'b1, 1'b1);
        put(13'h0080, 32'hffffffff, 1'b0, 1'b0);
        get("isr ns", 13'h0080, 32'h0, 1'b1, 1'b0);
        put(13'h101c, 32'h5, 1'b0, 1'b0);
        get("abp ns", 13'h101c, BP, 1'b1, 1'b0);
        get("abp ns rd", 13'h101c, 32'h0, 1'b0, 1'b0);
        $display("banking done");
    endtask
    task automatic t_irq;
        int n;
        put(13'h0100, 32'h20, 1'b1, 1'b0);
        put(13'h1004, 32'hf0, 1'b1, 1'b0);
        put(13'h1000, 32'h3, 1'b1, 1'b0);
        put(13'h0f00, 32'h5, 1'b1, 1'b0);
        repeat (4) @(negedge clk);
        chk("irq off", 32'h0, {30'h0, irq});
        put(13'h0000, 32'h1, 1'b1, 1'b0);
        for (n = 0; n < 20 && irq[0] !== 1'b1; n++) begin
            @(negedge clk);
        end
        chk("irq0", 32'h1, {31'h0, irq[0]});
        if (n == 20) begin
            results;
        end
        chk("irq1", 32'h0, {31'h0, irq[1]});
        get("ack id", 13'h100c, 32'h5, 1'b1, 1'b0);
        put(13'h1010, 32'h5, 1'b1, 1'b0);
        get("runpri", 13'h1014, 32'hff, 1'b1, 1'b0);
        put(13'h1000, 32'h0, 1'b1, 1'b0);
        put(13'h0f00, 32'h5, 1'b1, 1'b0);
        repeat (4) @(negedge clk);
        chk("irq if off", 32'h0, {30'h0, irq});
        get("hipend", 13'h1018, `ICR_SPURIOUS, 1'b1, 1'b0);
        get("ack off", 13'h100c, `ICR_SPURIOUS, 1'b1, 1'b0);
        $display("interrupt flow done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_access;
        t_bank;
        t_irq;
        results;
    end
endmodule
`default_nettype wire
